// [common/pcl_pkg.sv]
`default_nettype none

package pcl_pkg;

    // Bus shape
    localparam int unsigned PCL_AW = 8;
    localparam int unsigned PCL_DW = 32;
    localparam logic [3:0] PCL_STRB_ALL = 4'hF;

    // Register byte offsets
    localparam logic [7:0] PCL_OFS_CFG_LO = 8'h00;
    localparam logic [7:0] PCL_OFS_CFG_HI = 8'h04;
    localparam logic [7:0] PCL_OFS_LATCH = 8'h0C;
    localparam logic [7:0] PCL_OFS_CLR = 8'h14;
    localparam logic [7:0] PCL_OFS_LCK = 8'h18;

    // Field layout
    localparam int unsigned PCL_PINS = 16;
    localparam int unsigned PCL_NIB = 4;
    localparam int unsigned PCL_PINS_PER_CFG = 8;
    localparam int unsigned PCL_KEY_BIT = 16;

    // Reset values
    localparam logic [31:0] PCL_CFG_RST = 32'h44444444;
    localparam logic [15:0] PCL_LATCH_RST = 16'h0000;
    localparam logic [15:0] PCL_LCK_RST = 16'h0000;

    // Lock key sequence tracker
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ONE = 3'h1,
        ST_ZERO = 3'h2,
        ST_ARMED = 3'h3,
        ST_LOCKED = 3'h4
    } pcl_lock_e;

    // Signals toward the rest of the port
    typedef struct packed {
        logic [31:0] cfg_high;
        logic [31:0] cfg_low;
        logic [15:0] latch;
    } pcl_port_s;

endpackage : pcl_pkg

`default_nettype wire

// [rtl/pcl_port_lock.sv]
// Contract
// R1: Writing 1 to a clear bit clears that output latch bit; 0 does nothing.
// R2: Clear bits are write-only and act only on full word writes.
// R3: The lock arms only through the correct key bit write sequence.
// R4: Software writes key 1, 0, 1, then reads key back as 0.
// R5: A further read after that returns key 1, showing the lock is active.
// R6: Software keeps the pin lock bits equal in every sequence write.
// R7: A wrong sequence step abandons the sequence; no lock results.
// R8: Locked pin configuration ignores writes until the next reset.
// R9: Each pin lock bit freezes its pin's 4-bit mode and config nibble.
// R10: Key bit is always readable and changes only via the key sequence.
// R11: Key 1 means locked; the whole lock register then freezes till reset.
// R12: Pin lock bits are read-write but writable only while key reads 0.
// R13: Pin lock bit 1 selects the pin for locking; 0 leaves it free.
// R14: Software sets 2-bit mode and config per pin in low or high register.
// R15: Any other lock register access mid-sequence restarts the tracking.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module pcl_port_lock (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pcl_pkg::PCL_AW-1:0] paddr,
    input wire logic [pcl_pkg::PCL_DW-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [pcl_pkg::PCL_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output pcl_pkg::pcl_port_s port_o,
    output logic lock_active
);
    import pcl_pkg::*;

    logic prep_ff;
    logic [PCL_DW-1:0] prdata_ff;
    logic [PCL_DW-1:0] cfg_lo_ff;
    logic [PCL_DW-1:0] cfg_hi_ff;
    logic [PCL_PINS-1:0] latch_ff;
    logic [PCL_PINS-1:0] pin_lock_ff;
    pcl_lock_e st_ff;
    pcl_lock_e nxt_st;

    logic [PCL_DW-1:0] nxt_cfg_lo;
    logic [PCL_DW-1:0] nxt_cfg_hi;
    logic [PCL_PINS-1:0] nxt_latch;

    // Bus decode
    wire logic xfer_go;
    wire logic acc_wr;
    wire logic acc_rd;
    wire logic hit_lo;
    wire logic hit_hi;
    wire logic hit_latch;
    wire logic hit_clr;
    wire logic hit_lck;
    wire logic mapped;
    wire logic word_wr;
    wire logic cap;

    assign xfer_go = psel & penable & pready;
    assign acc_wr = xfer_go & pwrite;
    assign acc_rd = xfer_go & ~pwrite;
    assign hit_lo = (paddr == PCL_OFS_CFG_LO);
    assign hit_hi = (paddr == PCL_OFS_CFG_HI);
    assign hit_latch = (paddr == PCL_OFS_LATCH);
    assign hit_clr = (paddr == PCL_OFS_CLR);
    assign hit_lck = (paddr == PCL_OFS_LCK);
    assign mapped = hit_lo | hit_hi | hit_latch | hit_clr | hit_lck;
    assign word_wr = (pstrb == PCL_STRB_ALL);
    assign cap = psel & ~prep_ff;

    // Qualified accesses
    wire logic wr_lo;
    wire logic wr_hi;
    wire logic wr_latch;
    wire logic wr_clr;
    wire logic wr_lck;
    wire logic rd_lck;

    assign wr_lo = acc_wr & hit_lo;
    assign wr_hi = acc_wr & hit_hi;
    assign wr_latch = acc_wr & hit_latch & word_wr;
    // R2 word only
    assign wr_clr = acc_wr & hit_clr & word_wr;
    assign wr_lck = acc_wr & hit_lck;
    assign rd_lck = acc_rd & hit_lck;

    // Lock state
    wire logic locked;
    wire logic key_wr;
    wire logic [PCL_PINS-1:0] pins_wr;
    wire logic pins_same;
    wire logic [PCL_PINS-1:0] frz_pins;
    pcl_lock_e seq_start;

    assign locked = (st_ff == ST_LOCKED);
    assign key_wr = pwdata[PCL_KEY_BIT];
    assign pins_wr = pwdata[PCL_PINS-1:0];
    assign pins_same = (pins_wr == pin_lock_ff);
    // R13 select pins
    assign frz_pins = {PCL_PINS{locked}} & pin_lock_ff;
    assign seq_start = key_wr ? ST_ONE : ST_IDLE;

    // Per-pin nibble masks
    wire logic [PCL_DW-1:0] frz_lo;
    wire logic [PCL_DW-1:0] frz_hi;
    wire logic [PCL_DW-1:0] byte_mask;

    assign byte_mask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                        {8{pstrb[1]}}, {8{pstrb[0]}}};

    // R9 nibble freeze
    for (genvar g = 0; g < PCL_PINS_PER_CFG; g++) begin : g_frz
        assign frz_lo[g*PCL_NIB +: PCL_NIB] = {PCL_NIB{frz_pins[g]}};
        assign frz_hi[g*PCL_NIB +: PCL_NIB] =
            {PCL_NIB{frz_pins[g+PCL_PINS_PER_CFG]}};
    end

    wire logic [PCL_DW-1:0] wmask_lo;
    wire logic [PCL_DW-1:0] wmask_hi;

    // R8 ignore locked writes
    assign wmask_lo = {PCL_DW{wr_lo}} & byte_mask & ~frz_lo;
    assign wmask_hi = {PCL_DW{wr_hi}} & byte_mask & ~frz_hi;
    assign nxt_cfg_lo = (cfg_lo_ff & ~wmask_lo) | (pwdata & wmask_lo);
    assign nxt_cfg_hi = (cfg_hi_ff & ~wmask_hi) | (pwdata & wmask_hi);

    // R1 clear latch bits
    assign nxt_latch = wr_clr ? (latch_ff & ~pins_wr) :
                       wr_latch ? pins_wr : latch_ff;

    // Read data select
    wire logic [PCL_DW-1:0] lck_rd_val;
    wire logic [PCL_DW-1:0] rd_mux;

    // R10 key readable
    assign lck_rd_val = {{(PCL_DW-PCL_PINS-1){1'b0}}, locked, pin_lock_ff};
    assign rd_mux = hit_lo ? cfg_lo_ff :
                    hit_hi ? cfg_hi_ff :
                    hit_latch ? {{(PCL_DW-PCL_PINS){1'b0}}, latch_ff} :
                    hit_lck ? lck_rd_val : '0;

    // R3 key sequence
    always_comb begin
        nxt_st = st_ff;
        unique case (st_ff)
            ST_IDLE: begin
                if (wr_lck) begin
                    nxt_st = seq_start;
                end
            end
            // R7 abort on error
            ST_ONE: begin
                if (wr_lck) begin
                    nxt_st = (!key_wr && pins_same) ? ST_ZERO : seq_start;
                end else if (rd_lck) begin
                    nxt_st = ST_IDLE;
                end
            end
            // R15 read restarts
            ST_ZERO: begin
                if (wr_lck) begin
                    nxt_st = (key_wr && pins_same) ? ST_ARMED : seq_start;
                end else if (rd_lck) begin
                    nxt_st = ST_IDLE;
                end
            end
            // R5 read confirms lock
            ST_ARMED: begin
                if (rd_lck) begin
                    nxt_st = ST_LOCKED;
                end else if (wr_lck) begin
                    nxt_st = seq_start;
                end
            end
            // R11 held until reset
            ST_LOCKED: begin
                nxt_st = ST_LOCKED;
            end
            default: begin
                nxt_st = ST_IDLE;
            end
        endcase
    end

    // Bus answer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prep_ff <= 1'b0;
            prdata_ff <= '0;
        end else if (ce) begin
            if (cap) begin
                prep_ff <= 1'b1;
                prdata_ff <= rd_mux;
            end else if (xfer_go) begin
                prep_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_lo_ff <= PCL_CFG_RST;
            cfg_hi_ff <= PCL_CFG_RST;
            latch_ff <= PCL_LATCH_RST;
        end else if (ce) begin
            cfg_lo_ff <= nxt_cfg_lo;
            cfg_hi_ff <= nxt_cfg_hi;
            latch_ff <= nxt_latch;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_ff <= ST_IDLE;
            pin_lock_ff <= PCL_LCK_RST;
        end else if (ce) begin
            st_ff <= nxt_st;
            // R12 write while key 0
            if (wr_lck && !locked) begin
                pin_lock_ff <= pins_wr;
            end
        end
    end

    assign pready = ce & prep_ff;
    assign pslverr = pready & ~mapped;
    assign prdata = prdata_ff;
    assign port_o = {cfg_hi_ff, cfg_lo_ff, latch_ff};
    assign lock_active = locked;

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_clear_bits_drop: assert property ( // R1
        wr_clr |=> ((latch_ff & $past(pins_wr)) == '0)
    ) else $error("Written clear bit left latch set");

    a_clear_zero_keep: assert property ( // R1
        wr_clr |=> ((latch_ff & ~$past(pins_wr))
                    == ($past(latch_ff) & ~$past(pins_wr)))
    ) else $error("Zero clear bit changed latch");

    a_clear_word_only: assert property ( // R2
        (acc_wr && hit_clr && !word_wr) |=> $stable(latch_ff)
    ) else $error("Partial clear write changed latch");

    a_key_rise_seq: assert property ( // R3
        $rose(locked) |-> ($past(st_ff) == ST_ARMED && $past(rd_lck))
    ) else $error("Lock set outside key sequence");

    a_read_zero_one: assert property ( // R5
        (rd_lck && st_ff == ST_ARMED && prdata[PCL_KEY_BIT] == 1'b0)
        |=> (locked && lck_rd_val[PCL_KEY_BIT])
    ) else $error("Confirming read did not lock");

    a_bad_step_abort: assert property ( // R7
        (wr_lck && st_ff == ST_ZERO && !pins_same)
        |=> (st_ff != ST_ARMED)
    ) else $error("Mismatched pins still armed");

    a_bad_key_abort: assert property ( // R7
        (wr_lck && st_ff == ST_ONE && key_wr) |=> (st_ff == ST_ONE)
    ) else $error("Repeated key 1 did not restart");

    a_cfg_lo_frozen: assert property ( // R8
        locked |=> ((cfg_lo_ff & frz_lo) == $past(cfg_lo_ff & frz_lo))
    ) else $error("Locked low nibble changed");

    a_cfg_hi_frozen: assert property ( // R9
        locked |=> ((cfg_hi_ff & frz_hi) == $past(cfg_hi_ff & frz_hi))
    ) else $error("Locked high nibble changed");

    a_lock_sticky: assert property ( // R11
        locked |=> locked [*3]
    ) else $error("Lock dropped before reset");

    a_pins_frozen: assert property ( // R12
        locked |=> $stable(pin_lock_ff)
    ) else $error("Pin lock bits changed while locked");

    a_pins_written: assert property ( // R12
        (wr_lck && !locked) |=> (pin_lock_ff == $past(pins_wr))
    ) else $error("Pin lock write lost");

    a_free_pin_write: assert property ( // R13
        (wr_lo && word_wr && !frz_pins[0])
        |=> (cfg_lo_ff[PCL_NIB-1:0] == $past(pwdata[PCL_NIB-1:0]))
    ) else $error("Unlocked pin write ignored");

    a_read_restart: assert property ( // R15
        (rd_lck && (st_ff == ST_ONE || st_ff == ST_ZERO))
        |=> (st_ff == ST_IDLE)
    ) else $error("Mid-sequence read kept tracking");

    a_answer_time: assert property (
        (psel && !penable && ce && !prep_ff) |=> prep_ff
    ) else $error("Setup cycle not answered");

    a_answer_ends: assert property (
        xfer_go |=> !pready
    ) else $error("Ready held past transfer");

    a_clear_reads_zero: assert property ( // R2
        (cap && ce && hit_clr)
        |=> (prdata == '0)
    ) else $error("Clear register read not zero");

    a_unmapped_zero: assert property (
        (cap && ce && !mapped)
        |=> (prdata == '0)
    ) else $error("Unmapped read not zero");

    a_key_plain_write: assert property ( // R10
        (wr_lck && st_ff == ST_IDLE)
        |=> !locked
    ) else $error("Plain write set key");

    a_armed_needs_read: assert property ( // R3
        (st_ff == ST_ARMED && !rd_lck)
        |=> !locked
    ) else $error("Lock set without confirming read");

    a_write_restart: assert property ( // R15
        (wr_lck && st_ff == ST_ARMED)
        |=> (st_ff == ST_ONE || st_ff == ST_IDLE)
    ) else $error("Armed write kept tracking");

    a_free_high_pin: assert property ( // R13
        (wr_hi && word_wr && !frz_pins[PCL_PINS-1])
        |=> (cfg_hi_ff[PCL_DW-1 -: PCL_NIB]
             == $past(pwdata[PCL_DW-1 -: PCL_NIB]))
    ) else $error("Unlocked high pin write ignored");

    a_ce_freeze: assert property (
        !ce |=> ($stable(st_ff) && $stable(pin_lock_ff)
                 && $stable(latch_ff) && $stable(cfg_lo_ff)
                 && $stable(cfg_hi_ff))
    ) else $error("State moved while enable low");

endmodule : pcl_port_lock

`default_nettype wire

// [tb/tb_pcl_port_lock.sv]
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end

module tb_pcl_port_lock;
    import pcl_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    pcl_port_s port_o;
    logic lock_active;
    int num_errors = 0;
    int checked = 0;

    pcl_port_lock pcl_port_lock_inst (.clk(clk), .resetn(resetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port_o(port_o), .lock_active(lock_active));

    always #2 clk = ~clk;

    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [3:0] s,
        output logic [31:0] r, output logic e);
        int n;
        logic rdy;
        n = 0;
        rdy = 1'b0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        while (rdy !== 1'b1 && n < 50) begin
            @(posedge clk);
            rdy = pready;
            r = prdata;
            e = pslverr;
            n++;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (rdy !== 1'b1) num_errors++;
        @(negedge clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, s, r, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] x,
        input string nm);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h00000000, 4'hF, r, e);
        `CHK(nm, x, r)
    endtask : rd

    task automatic keyseq(input logic [31:0] a, input logic [31:0] b,
        input logic [31:0] c, input logic mid);
        wr(PCL_OFS_LCK, a, 4'hF);
        wr(PCL_OFS_LCK, b, 4'hF);
        if (mid) rd(PCL_OFS_LCK, b, "lock mid");
        wr(PCL_OFS_LCK, c, 4'hF);
    endtask : keyseq

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        stop_test();
    end

    initial begin
        logic [31:0] r;
        logic e;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        rd(PCL_OFS_CFG_LO, PCL_CFG_RST, "cfg lo rst");
        rd(PCL_OFS_LCK, 32'h00000000, "lock rst");
        $display("test reset done");
        wr(PCL_OFS_LATCH, 32'h0000FFFF, 4'hF);
        wr(PCL_OFS_CLR, 32'h000000A5, 4'hF);
        `CHK("latch", 16'hFF5A, port_o.latch)
        wr(PCL_OFS_CLR, 32'h0000FF00, 4'h3);
        wr(PCL_OFS_CLR, 32'hFFFF0000, 4'hF);
        rd(PCL_OFS_LATCH, 32'h0000FF5A, "latch rd");
        rd(PCL_OFS_CLR, 32'h00000000, "clear rd");
        apb(1'b0, 8'h40, 32'h00000000, 4'hF, r, e);
        `CHK("unmapped err", 1'b1, e)
        `CHK("unmapped data", 32'h00000000, r)
        $display("test clear done");
        @(posedge clk);
        ce <= 1'b0;
        fork
            wr(PCL_OFS_LATCH, 32'h00001234, 4'hF);
            begin
                repeat (4) @(posedge clk);
                `CHK("ce hold rdy", 1'b0, pready)
                `CHK("ce hold latch", 16'hFF5A, port_o.latch)
                ce <= 1'b1;
            end
        join
        rd(PCL_OFS_LATCH, 32'h00001234, "latch ce");
        $display("test enable done");
        wr(PCL_OFS_LCK, 32'h00010000, 4'hF);
        rd(PCL_OFS_LCK, 32'h00000000, "key plain");
        keyseq(32'h00010101, 32'h00000101, 32'h00000101, 1'b0);
        rd(PCL_OFS_LCK, 32'h00000101, "bad step");
        rd(PCL_OFS_LCK, 32'h00000101, "bad step 2");
        keyseq(32'h00010101, 32'h00000101, 32'h00010303, 1'b0);
        rd(PCL_OFS_LCK, 32'h00000303, "pins moved");
        rd(PCL_OFS_LCK, 32'h00000303, "pins moved 2");
        keyseq(32'h00010101, 32'h00000101, 32'h00010101, 1'b1);
        rd(PCL_OFS_LCK, 32'h00000101, "mid read");
        rd(PCL_OFS_LCK, 32'h00000101, "mid read 2");
        keyseq(32'h00010101, 32'h00000101, 32'h00010101, 1'b0);
        wr(PCL_OFS_LCK, 32'h00000101, 4'hF);
        rd(PCL_OFS_LCK, 32'h00000101, "armed write");
        rd(PCL_OFS_LCK, 32'h00000101, "armed write 2");
        `CHK("not locked", 1'b0, lock_active)
        $display("test bad sequence done");
        wr(PCL_OFS_CFG_LO, 32'h33333333, 4'hF);
        wr(PCL_OFS_CFG_HI, 32'h55555555, 4'hF);
        wr(PCL_OFS_LCK, 32'h00010101, 4'hF);
        keyseq(32'h00010101, 32'h00000101, 32'h00010101, 1'b0);
        rd(PCL_OFS_LCK, 32'h00000101, "key read 0");
        rd(PCL_OFS_LCK, 32'h00010101, "key read 1");
        `CHK("locked", 1'b1, lock_active)
        wr(PCL_OFS_LCK, 32'h0000FFFF, 4'hF);
        keyseq(32'h00010000, 32'h00000000, 32'h00010000, 1'b0);
        rd(PCL_OFS_LCK, 32'h00010101, "lock frozen");
        rd(PCL_OFS_LCK, 32'h00010101, "lock frozen 2");
        wr(PCL_OFS_CFG_LO, 32'h12345678, 4'hF);
        wr(PCL_OFS_CFG_HI, 32'h9ABCDEF0, 4'hF);
        rd(PCL_OFS_CFG_LO, 32'h12345673, "cfg lo");
        rd(PCL_OFS_CFG_HI, 32'h9ABCDEF5, "cfg hi");
        `CHK("cfg lo out", 32'h12345673, port_o.cfg_low)
        `CHK("cfg hi out", 32'h9ABCDEF5, port_o.cfg_high)
        $display("test lock done");
        @(posedge clk);
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        `CHK("reset unlock", 1'b0, lock_active)
        rd(PCL_OFS_LCK, 32'h00000000, "lock after rst");
        rd(PCL_OFS_CFG_HI, PCL_CFG_RST, "cfg hi rst");
        wr(PCL_OFS_CFG_LO, 32'h12345678, 4'hF);
        rd(PCL_OFS_CFG_LO, 32'h12345678, "cfg lo free");
        $display("test second reset done");
        stop_test();
    end
endmodule : tb_pcl_port_lock

`default_nettype wire
